// *** rtl/ebt_pkg.sv ***
// shared constants, types and reset values of the external bus timing block
package ebt_pkg;
  localparam int CNT_W = 8;
  localparam int WAIT_W = 5;
  localparam int BYTE_SEL = 0;

  // reset values of the timing fields
  localparam logic [WAIT_W-1:0] RD_WAIT_RST = 5'h1f;
  localparam logic [WAIT_W-1:0] RD_DELAY_RST = 5'h01;
  localparam logic [WAIT_W-1:0] WR_WAIT_RST = 5'h1f;
  localparam logic [WAIT_W-1:0] WR_DELAY_RST = 5'h00;
  localparam logic FULL_RATE_RST = 1'h0; // bus clock is half the system clock
  localparam logic LATCH_TWO_RST = 1'h0; // latch pulse one bus period long
  localparam logic MUX_RST = 1'h1;

  // counts in bus periods and in system cycles
  localparam logic [5:0] PER_ONE = 6'h01;
  localparam logic [5:0] PER_TWO = 6'h02;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] HALF_CYC = 8'h01; // half a bus period
  localparam logic [15:0] ADDR_STEP = 16'h0001;

  typedef enum logic [2:0] {
    EBT_IDLE, EBT_PRESET, EBT_LATCH, EBT_LHOLD, EBT_WAIT, EBT_STROBE,
    EBT_WHOLD
  } ebt_state_e;

  typedef struct packed {
    logic [7:0] up;
    logic [15:0] low;
  } ebt_addr_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } ebt_data_s;

  typedef struct packed {
    logic full_rate;
    logic latch_two;
    logic mux;
    logic [WAIT_W-1:0] rd_wait;
    logic [WAIT_W-1:0] rd_delay;
    logic [WAIT_W-1:0] wr_wait;
    logic [WAIT_W-1:0] wr_delay;
  } ebt_cfg_s;

  localparam ebt_cfg_s CFG_RST = '{FULL_RATE_RST, LATCH_TWO_RST, MUX_RST,
    RD_WAIT_RST, RD_DELAY_RST, WR_WAIT_RST, WR_DELAY_RST};
endpackage

// *** rtl/ebt_tmr_if.sv ***
// phase timer handshake between the cycle sequencer and its timer
`timescale 1ns/10ps
interface ebt_tmr_if;
  logic load;
  logic [ebt_pkg::CNT_W-1:0] count;
  logic done;
  modport owner (output load, output count, input done);
  modport timer (input load, input count, output done);
endinterface

// *** rtl/ebt_timer.sv ***
// phase length down counter used by the bus cycle sequencer
`timescale 1ns/10ps
module ebt_timer (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  ebt_tmr_if.timer tmr
);
  typedef struct packed {
    logic [ebt_pkg::CNT_W-1:0] cnt;
  } ebt_tmr_s;

  ebt_tmr_s st_q;
  ebt_tmr_s st_d;

  // load wins over the running count, stop at zero
  always_comb begin
    st_d = st_q;
    if (tmr.load) begin
      st_d.cnt = tmr.count;
    end else if (st_q.cnt != ebt_pkg::CNT_ZERO) begin
      st_d.cnt = st_q.cnt - ebt_pkg::CNT_ONE;
    end
  end

  // done marks the last cycle of the loaded phase
  assign tmr.done = (st_q.cnt == ebt_pkg::CNT_ONE);

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
endmodule

// *** rtl/ebt_cycle.sv ***
// external bus cycle timing generator, multiplexed and non-multiplexed
// What this block does
// - time cycles from an internal bus clock that never reaches a pin
// - bus clock is system clock times ratio; half after reset, full option
// - latch pulse lasts one bus period after reset, two when programmed
// - address driven latch-length before pulse end, held half period after
// - read strobe starts read-delay periods after chip select, reset one; in mux mode not before latch and its hold end
// - read strobe lasts read wait minus read delay plus one periods
// - read end: chip select rises with read strobe; address released then
// - write strobe starts write-delay periods after chip select, reset zero; in mux mode not before one cycle past latch hold
// - write strobe lasts write wait minus write delay plus one periods
// - data, address, select held half period after write strobe rises
// - non-mux write data and address lead strobe by delay plus half
// - mux write data lead is delay minus 1.5, or 2.5 with long latch
// - wide write on byte bus splits; second address lead is delay minus half
// - mux: shared lines carry address then data; upper address separate
`timescale 1ns/10ps
module ebt_cycle (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic cfg_load_in,
  input wire logic bus_clock_divide_ratio_in,
  input wire logic address_latch_two_in,
  input wire logic mux_mode_in,
  input wire logic [4:0] read_wait_count_in,
  input wire logic [4:0] read_strobe_delay_count_in,
  input wire logic [4:0] write_wait_count_in,
  input wire logic [4:0] write_strobe_delay_count_in,
  input wire logic req_in,
  input wire logic req_write_in,
  input wire logic req_wide_in,
  input wire logic [23:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  output logic req_ready_out,
  output logic ack_out,
  output logic [15:0] rdata_out,
  output logic busy_out,
  output logic chip_select_n_out,
  output logic address_latch_pulse_out,
  output logic read_strobe_n_out,
  output logic write_low_byte_strobe_n_out,
  output logic write_high_byte_strobe_n_out,
  output logic [15:0] shared_addr_data_lines_out,
  output logic shared_addr_data_lines_oe_out,
  input wire logic [15:0] shared_addr_data_lines_in,
  output logic [7:0] upper_address_lines_out,
  output logic [15:0] low_address_lines_out
);
  typedef struct packed {
    ebt_pkg::ebt_state_e st;
    ebt_pkg::ebt_cfg_s cfg;
    logic bus_clk;
    logic write;
    logic wide;
    logic second;
    ebt_pkg::ebt_addr_s addr;
    ebt_pkg::ebt_data_s wdata;
    logic cs_n;
    logic ale;
    logic rd_n;
    logic wrl_n;
    logic wrh_n;
    logic [15:0] ad_out;
    logic ad_oe;
    logic [15:0] low_addr;
    logic [7:0] up_addr;
    logic ack;
    logic [15:0] rdata;
    logic [15:0] sync1;
    logic [15:0] sync2;
    logic [7:0] ale_cnt;
    logic [7:0] cs_cnt;
    logic [7:0] stb_cnt;
  } ebt_cyc_s;

  ebt_cyc_s st_q;
  ebt_cyc_s st_d;
  ebt_tmr_if tmr ();

  logic start_ok;
  logic go_wait;
  logic lane_lo;
  logic lane_hi;
  logic [7:0] wait_cyc;
  logic [7:0] ale_cyc;
  logic [7:0] rd_delay_cyc;
  logic [7:0] wr_delay_cyc;
  logic [7:0] rd_len_cyc;
  logic [7:0] wr_len_cyc;
  logic [7:0] rd_pre_cyc;
  logic [7:0] wr_pre_cyc;
  logic [5:0] rd_len_per;
  logic [5:0] wr_len_per;

  ebt_timer u_timer (
    .sys_clk_in(sys_clk_in),
    .reset_n_in(reset_n_in),
    .tmr(tmr.timer)
  );

  // bus periods to system cycles; full rate has no half point, so a half
  // period rounds up to one cycle there
  function automatic logic [7:0] per(input logic full, input logic [5:0] n);
    per = full ? {2'h0, n} : {1'h0, n, 1'h0};
  endfunction

  function automatic logic [7:0] max8(input logic [7:0] a, input logic [7:0] b);
    max8 = (a > b) ? a : b;
  endfunction

  // phase lengths from the live configuration
  always_comb begin
    ale_cyc = per(st_q.cfg.full_rate,
      st_q.cfg.latch_two ? ebt_pkg::PER_TWO : ebt_pkg::PER_ONE);
    rd_delay_cyc = per(st_q.cfg.full_rate, {1'h0, st_q.cfg.rd_delay});
    wr_delay_cyc = per(st_q.cfg.full_rate, {1'h0, st_q.cfg.wr_delay});
    // a wait below its delay would give a negative width: clamp to one
    rd_len_per = (st_q.cfg.rd_wait >= st_q.cfg.rd_delay) ?
      {1'h0, st_q.cfg.rd_wait} - {1'h0, st_q.cfg.rd_delay} + ebt_pkg::PER_ONE :
      ebt_pkg::PER_ONE;
    wr_len_per = (st_q.cfg.wr_wait >= st_q.cfg.wr_delay) ?
      {1'h0, st_q.cfg.wr_wait} - {1'h0, st_q.cfg.wr_delay} + ebt_pkg::PER_ONE :
      ebt_pkg::PER_ONE;
    rd_len_cyc = per(st_q.cfg.full_rate, rd_len_per);
    wr_len_cyc = per(st_q.cfg.full_rate, wr_len_per);
    // mux: strobe cannot start before the latch and its hold are over
    rd_pre_cyc = st_q.cfg.mux ?
      max8(rd_delay_cyc, ale_cyc + ebt_pkg::HALF_CYC) : rd_delay_cyc;
    wr_pre_cyc = st_q.cfg.mux ? max8(wr_delay_cyc,
      ale_cyc + ebt_pkg::HALF_CYC + ebt_pkg::CNT_ONE) : wr_delay_cyc;
  end

  // cycles start only on a rising bus clock edge
  assign start_ok = st_q.cfg.full_rate || !st_q.bus_clk;
  assign req_ready_out = (st_q.st == ebt_pkg::EBT_IDLE) && start_ok;

  // sequencer: every phase is timed by the shared down counter
  always_comb begin
    st_d = st_q;
    go_wait = 1'h0;
    wait_cyc = ebt_pkg::CNT_ZERO;
    tmr.load = 1'h0;
    tmr.count = ebt_pkg::CNT_ONE;
    st_d.ack = 1'h0;
    st_d.sync1 = shared_addr_data_lines_in;
    st_d.sync2 = st_q.sync1;
    st_d.bus_clk = st_q.cfg.full_rate ? 1'h0 : ~st_q.bus_clk;
    st_d.ale_cnt = st_q.ale ? st_q.ale_cnt + ebt_pkg::CNT_ONE : ebt_pkg::CNT_ZERO;
    st_d.cs_cnt = st_q.cs_n ? ebt_pkg::CNT_ZERO : st_q.cs_cnt + ebt_pkg::CNT_ONE;
    st_d.stb_cnt = (st_q.rd_n && st_q.wrl_n && st_q.wrh_n) ?
      ebt_pkg::CNT_ZERO : st_q.stb_cnt + ebt_pkg::CNT_ONE;
    unique case (st_q.st)
      ebt_pkg::EBT_IDLE: begin
        // configuration only moves between cycles
        if (cfg_load_in) begin
          st_d.cfg = '{bus_clock_divide_ratio_in, address_latch_two_in,
            mux_mode_in, read_wait_count_in, read_strobe_delay_count_in,
            write_wait_count_in, write_strobe_delay_count_in};
        end
        if (req_in && start_ok) begin
          st_d.write = req_write_in;
          st_d.wide = req_wide_in;
          st_d.second = 1'h0;
          st_d.addr = req_addr_in;
          st_d.wdata = req_wdata_in;
          st_d.up_addr = st_d.addr.up;
          if (st_q.cfg.mux) begin
            // address on the shared lines for the latch pulse
            st_d.st = ebt_pkg::EBT_LATCH;
            st_d.cs_n = 1'h0;
            st_d.ale = 1'h1;
            st_d.ad_out = st_d.addr.low;
            st_d.ad_oe = 1'h1;
            tmr.load = 1'h1;
            tmr.count = ale_cyc;
          end else if (req_write_in) begin
            // half period of address and data ahead of the select
            st_d.st = ebt_pkg::EBT_PRESET;
            st_d.low_addr = st_d.addr.low;
            st_d.ad_out = {8'h00, st_d.wdata.lo};
            st_d.ad_oe = 1'h1;
            tmr.load = 1'h1;
            tmr.count = ebt_pkg::HALF_CYC;
          end else begin
            st_d.low_addr = st_d.addr.low;
            st_d.cs_n = 1'h0;
            go_wait = 1'h1;
            wait_cyc = rd_delay_cyc;
          end
        end
      end
      ebt_pkg::EBT_PRESET: begin
        if (tmr.done) begin
          st_d.cs_n = 1'h0;
          go_wait = 1'h1;
          wait_cyc = wr_delay_cyc;
        end
      end
      ebt_pkg::EBT_LATCH: begin
        if (tmr.done) begin
          st_d.ale = 1'h0;
          st_d.st = ebt_pkg::EBT_LHOLD;
          tmr.load = 1'h1;
          tmr.count = ebt_pkg::HALF_CYC;
        end
      end
      ebt_pkg::EBT_LHOLD: begin
        if (tmr.done) begin
          // shared lines turn from address to data, or float for a read
          if (st_q.write) begin
            st_d.ad_out = st_q.wide ? st_q.wdata :
              {st_q.wdata.lo, st_q.wdata.lo};
          end else begin
            st_d.ad_oe = 1'h0;
          end
          go_wait = 1'h1;
          wait_cyc = (st_q.write ? wr_pre_cyc : rd_pre_cyc) - ale_cyc -
            ebt_pkg::HALF_CYC;
        end
      end
      ebt_pkg::EBT_WAIT: begin
        if (tmr.done) begin
          go_wait = 1'h1;
        end
      end
      ebt_pkg::EBT_STROBE: begin
        if (tmr.done) begin
          if (st_q.write) begin
            st_d.wrl_n = 1'h1;
            st_d.wrh_n = 1'h1;
            st_d.st = ebt_pkg::EBT_WHOLD;
            tmr.load = 1'h1;
            tmr.count = ebt_pkg::HALF_CYC;
          end else begin
            // select, strobe and address all drop on the same edge
            st_d.rd_n = 1'h1;
            st_d.cs_n = 1'h1;
            st_d.ad_oe = 1'h0;
            st_d.low_addr = '0;
            st_d.up_addr = '0;
            st_d.rdata = st_q.cfg.mux ? st_q.sync2 :
              {8'h00, st_q.sync2[7:0]};
            st_d.ack = 1'h1;
            st_d.st = ebt_pkg::EBT_IDLE;
          end
        end
      end
      ebt_pkg::EBT_WHOLD: begin
        if (tmr.done) begin
          if (!st_q.cfg.mux && st_q.wide && !st_q.second) begin
            // high byte at the next address, select kept low
            st_d.second = 1'h1;
            st_d.low_addr = st_q.addr.low + ebt_pkg::ADDR_STEP;
            st_d.ad_out = {8'h00, st_q.wdata.hi};
            go_wait = 1'h1;
            wait_cyc = (wr_delay_cyc > ebt_pkg::CNT_ZERO) ?
              wr_delay_cyc - ebt_pkg::HALF_CYC : ebt_pkg::CNT_ZERO;
          end else begin
            st_d.cs_n = 1'h1;
            st_d.ad_oe = 1'h0;
            st_d.low_addr = '0;
            st_d.up_addr = '0;
            st_d.ack = 1'h1;
            st_d.st = ebt_pkg::EBT_IDLE;
          end
        end
      end
      default: begin
        st_d.st = ebt_pkg::EBT_IDLE;
      end
    endcase
    // enter the strobe wait, or the strobe itself when no wait is left
    lane_lo = !st_d.cfg.mux || st_d.wide || !st_d.addr.low[ebt_pkg::BYTE_SEL];
    lane_hi = st_d.cfg.mux && (st_d.wide || st_d.addr.low[ebt_pkg::BYTE_SEL]);
    if (go_wait) begin
      tmr.load = 1'h1;
      if (wait_cyc == ebt_pkg::CNT_ZERO) begin
        st_d.st = ebt_pkg::EBT_STROBE;
        if (st_d.write) begin
          st_d.wrl_n = !lane_lo;
          st_d.wrh_n = !lane_hi;
          tmr.count = wr_len_cyc;
        end else begin
          st_d.rd_n = 1'h0;
          tmr.count = rd_len_cyc;
        end
      end else begin
        st_d.st = ebt_pkg::EBT_WAIT;
        tmr.count = wait_cyc;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      st_q <= '0;
      st_q.cfg <= ebt_pkg::CFG_RST;
      st_q.cs_n <= 1'h1;
      st_q.rd_n <= 1'h1;
      st_q.wrl_n <= 1'h1;
      st_q.wrh_n <= 1'h1;
    end else begin
      st_q <= st_d;
    end
  end

  // pins come straight from the state; the bus clock itself stays inside
  assign ack_out = st_q.ack;
  assign rdata_out = st_q.rdata;
  assign busy_out = (st_q.st != ebt_pkg::EBT_IDLE);
  assign chip_select_n_out = st_q.cs_n;
  assign address_latch_pulse_out = st_q.ale;
  assign read_strobe_n_out = st_q.rd_n;
  assign write_low_byte_strobe_n_out = st_q.wrl_n;
  assign write_high_byte_strobe_n_out = st_q.wrh_n;
  assign shared_addr_data_lines_out = st_q.ad_out;
  assign shared_addr_data_lines_oe_out = st_q.ad_oe;
  assign upper_address_lines_out = st_q.up_addr;
  assign low_address_lines_out = st_q.low_addr;

  // checks on the pin timing
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  logic wr_n;
  assign wr_n = st_q.wrl_n && st_q.wrh_n;

  sequence s_wr_held;
    !st_q.cs_n && st_q.ad_oe;
  endsequence
  sequence s_wr_released;
    (st_q.cs_n && !st_q.ad_oe) || st_q.st == ebt_pkg::EBT_WAIT ||
      st_q.st == ebt_pkg::EBT_STROBE;
  endsequence

  property p_align;
    (st_q.st == ebt_pkg::EBT_IDLE && st_d.st != ebt_pkg::EBT_IDLE) |->
      (st_q.cfg.full_rate || !st_q.bus_clk);
  endproperty
  a_align: assert property (p_align) else $error("cycle off bus edge");
  // the first edge after reset still sees the reset phase twice: skip it
  property p_ratio;
    ($past(reset_n_in) && !st_q.cfg.full_rate &&
      !$past(st_q.cfg.full_rate)) |->
      st_q.bus_clk != $past(st_q.bus_clk);
  endproperty
  a_ratio: assert property (p_ratio) else $error("bus clock not half");
  property p_ale_width;
    $fell(st_q.ale) |-> st_q.ale_cnt == ale_cyc;
  endproperty
  a_ale_width: assert property (p_ale_width) else $error("latch width");
  property p_addr_hold;
    $fell(st_q.ale) |-> st_q.ad_oe && st_q.ad_out == st_q.addr.low
      ##1 (st_q.write == st_q.ad_oe);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addr hold");
  property p_rd_delay;
    $fell(st_q.rd_n) |-> st_q.cs_cnt == rd_pre_cyc;
  endproperty
  a_rd_delay: assert property (p_rd_delay) else $error("read delay");
  property p_rd_width;
    $rose(st_q.rd_n) |-> st_q.stb_cnt == rd_len_cyc;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read width");
  property p_rd_end;
    $rose(st_q.rd_n) |-> $rose(st_q.cs_n) && !st_q.ad_oe && st_q.ack;
  endproperty
  a_rd_end: assert property (p_rd_end) else $error("read end");
  property p_wr_delay;
    ($fell(wr_n) && !st_q.second) |-> st_q.cs_cnt == wr_pre_cyc;
  endproperty
  a_wr_delay: assert property (p_wr_delay) else $error("write delay");
  property p_wr_width;
    $rose(wr_n) |-> st_q.stb_cnt == wr_len_cyc;
  endproperty
  a_wr_width: assert property (p_wr_width) else $error("write width");
  property p_wr_hold;
    $rose(wr_n) |-> s_wr_held ##1 s_wr_released;
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write hold");
  property p_nomux_setup;
    ($fell(st_q.cs_n) && st_q.write && !st_q.cfg.mux) |->
      $past(st_q.ad_oe) && $past(st_q.st) == ebt_pkg::EBT_PRESET;
  endproperty
  a_nomux_setup: assert property (p_nomux_setup) else $error("setup");
  property p_split;
    ($fell(wr_n) && st_q.second) |-> st_q.ad_out[7:0] == st_q.wdata.hi &&
      st_q.low_addr == st_q.addr.low + ebt_pkg::ADDR_STEP;
  endproperty
  a_split: assert property (p_split) else $error("second beat");
endmodule

// *** testbench/ebt_mem_model.sv ***
// byte-wide memory model standing on the far side of the bus pins
`timescale 1ns/10ps
module ebt_mem_model (
  input wire logic clk_in,
  input wire logic mux_in,
  input wire logic [3:0] lag_in,
  input wire logic ale_in,
  input wire logic rd_n_in,
  input wire logic wrl_n_in,
  input wire logic wrh_n_in,
  input wire logic [15:0] ad_in,
  input wire logic [15:0] la_in,
  output logic [15:0] ad_out
);
  logic [7:0] mem [256];
  logic [7:0] lat_q;
  logic [7:0] ea;
  logic [15:0] word;
  logic [15:0] last_q;
  logic [3:0] age_q;
  logic wrl_q;
  logic wrh_q;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'h00;
    lat_q = 8'h00;
    last_q = 16'h0000;
    age_q = 4'h0;
    wrl_q = 1'b1;
    wrh_q = 1'b1;
  end
  // mux mode addresses a byte pair from the latched address
  assign ea = mux_in ? {lat_q[7:1], 1'b0} : la_in[7:0];
  assign word = mux_in ? {mem[ea | 8'h01], mem[ea]} : {~last_q[15:8], mem[ea]};
  // slow answer: lines toggle until lag runs out, never a stale copy
  assign ad_out = (!rd_n_in && age_q >= lag_in) ? word : ~last_q;
  // write data taken at the strobe's rise while it is still held
  always @(posedge clk_in) begin
    if (ale_in) lat_q <= ad_in[7:0];
    if (rd_n_in) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
    last_q <= ad_out;
    if (!wrl_q && wrl_n_in) mem[ea] <= ad_in[7:0];
    if (!wrh_q && wrh_n_in) mem[ea | 8'h01] <= ad_in[15:8];
    wrl_q <= wrl_n_in;
    wrh_q <= wrh_n_in;
  end
endmodule

// *** testbench/ebt_cycle_tb_top.sv ***
// self-checking bench for the external bus cycle timing block
`timescale 1ns/10ps
module ebt_cycle_tb_top;
  typedef struct {logic [15:0] rd; bit chk; int slen; int alen; int dly;
    int gap; logic [7:0] up;} ebt_note_s;
  logic clk, rst_n, cfg_load, ratio, l2, mux, req, req_wr, req_wide;
  logic [4:0] rw, rdl, ww, wdl;
  logic [23:0] req_addr;
  logic [15:0] req_wdata, rdata, ad_o, ad_w, mem_o, la;
  logic ready, ack, busy, cs_n, ale, rd_n, wrl_n, wrh_n, ad_oe;
  logic [7:0] up, upc;
  logic [3:0] lag;
  logic [7:0] sh [256];
  ebt_note_s q [$];
  int n_fail, n_compared, cyc, scnt, slen, acnt, alen, dcnt, gapc;
  bit fst;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // resolved shared lines: design drives while its enable is high
  assign ad_w = ad_oe ? ad_o : mem_o;

  ebt_cycle u_dut (.sys_clk_in(clk), .reset_n_in(rst_n),
    .cfg_load_in(cfg_load), .bus_clock_divide_ratio_in(ratio),
    .address_latch_two_in(l2), .mux_mode_in(mux),
    .read_wait_count_in(rw), .read_strobe_delay_count_in(rdl),
    .write_wait_count_in(ww), .write_strobe_delay_count_in(wdl),
    .req_in(req), .req_write_in(req_wr), .req_wide_in(req_wide),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_ready_out(ready), .ack_out(ack), .rdata_out(rdata),
    .busy_out(busy), .chip_select_n_out(cs_n),
    .address_latch_pulse_out(ale), .read_strobe_n_out(rd_n),
    .write_low_byte_strobe_n_out(wrl_n),
    .write_high_byte_strobe_n_out(wrh_n),
    .shared_addr_data_lines_out(ad_o),
    .shared_addr_data_lines_oe_out(ad_oe),
    .shared_addr_data_lines_in(ad_w), .upper_address_lines_out(up),
    .low_address_lines_out(la));

  ebt_mem_model u_mem (.clk_in(clk), .mux_in(mux), .lag_in(lag),
    .ale_in(ale), .rd_n_in(rd_n), .wrl_n_in(wrl_n), .wrh_n_in(wrh_n),
    .ad_in(ad_w), .la_in(la), .ad_out(mem_o));

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one access: note the expectation, then hold the request until taken
  task automatic op(bit w, bit wide, logic [23:0] a, logic [15:0] d);
    ebt_note_s n;
    int p;
    logic [7:0] e;
    p = ratio ? 1 : 2;
    e = a[7:0];
    n.chk = !w;
    n.up = a[23:16];
    n.gap = w ? 1 : 0;
    n.alen = mux ? (l2 ? 2 : 1) * p : -1;
    n.dly = mux ? -1 : (w ? int'(wdl) : int'(rdl)) * p;
    n.slen = (w ? int'(ww) - int'(wdl) + 1 : int'(rw) - int'(rdl) + 1) * p;
    if (w && mux && wide) {sh[e | 8'h01], sh[e & 8'hfe]} = d;
    else if (w) sh[e] = d[7:0];
    if (w && !mux && wide) sh[e + 8'h01] = d[15:8];
    n.rd = mux ? {sh[e | 8'h01], sh[e & 8'hfe]} : {8'h00, sh[e]};
    q.push_back(n);
    @(posedge clk);
    req <= 1'b1;
    req_wr <= w;
    req_wide <= wide;
    req_addr <= a;
    req_wdata <= d;
    do @(negedge clk); while (ready !== 1'b1);
    @(posedge clk);
    req <= 1'b0;
    do @(negedge clk); while (ack !== 1'b1);
  endtask

  // fresh timing fields, loaded while idle
  task automatic cfg_rand();
    logic [4:0] r;
    logic [4:0] w;
    r = 5'($urandom_range(4, 1));
    w = 5'($urandom_range(4, 0));
    @(posedge clk);
    ratio <= 1'($urandom);
    l2 <= 1'($urandom);
    mux <= 1'($urandom);
    rdl <= r;
    rw <= r + 5'h02 + 5'($urandom_range(3, 0));
    wdl <= w;
    ww <= w + 5'($urandom_range(3, 0));
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
  endtask

  // pin watcher: measures pulse widths and spacing, compares at each ack
  always @(negedge clk) begin
    if (!rst_n) begin
      scnt = 0; slen = 0; acnt = 0; alen = 0; dcnt = 0; gapc = 0; fst = 0;
    end else begin
      if (ale) acnt++;
      else if (acnt != 0) begin alen = acnt; acnt = 0; end
      if (!cs_n) upc = up;
      if (!(rd_n & wrl_n & wrh_n)) begin
        scnt++; gapc = 0; fst = 1;
      end else begin
        if (scnt != 0) begin slen = scnt; scnt = 0; end
        if (!cs_n && fst) gapc++;
        if (!cs_n && !fst) dcnt++;
      end
      if (ack === 1'b1) begin
        if (q.size() == 0) check("spare ack", 1, 0);
        else begin
          ebt_note_s n;
          n = q.pop_front();
          if (n.chk) check("read data", rdata, n.rd);
          check("strobe width", slen, n.slen);
          check("select after strobe", gapc, n.gap);
          if (n.alen >= 0) check("latch width", alen, n.alen);
          if (n.dly >= 0) check("strobe delay", dcnt, n.dly);
          check("upper address", upc, n.up);
          check("select idle", cs_n, 1'b1);
          check("busy at end", busy, 1'b0);
        end
        dcnt = 0; alen = 0; fst = 0;
      end
    end
  end

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      end_sim();
    end
  end

  initial begin
    logic [23:0] a;
    rst_n = 1'b0; cfg_load = 1'b0; req = 1'b0; req_wr = 1'b0;
    req_wide = 1'b0; req_addr = 24'h000000; req_wdata = 16'h0000;
    ratio = ebt_pkg::FULL_RATE_RST; l2 = ebt_pkg::LATCH_TWO_RST;
    mux = ebt_pkg::MUX_RST; rw = ebt_pkg::RD_WAIT_RST;
    rdl = ebt_pkg::RD_DELAY_RST; ww = ebt_pkg::WR_WAIT_RST;
    wdl = ebt_pkg::WR_DELAY_RST; lag = 4'h3;
    n_fail = 0; n_compared = 0; cyc = 0;
    for (int i = 0; i < 256; i++) sh[i] = 8'h00;
    void'($urandom(20));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    // reset timing fields with a slow memory
    op(1'b1, 1'b1, 24'h5a0010, 16'hbeef);
    op(1'b0, 1'b1, 24'h5a0010, 16'h0000);
    @(posedge clk);
    lag <= 4'h0;
    // random modes, rates and counts; wide then odd byte accesses
    for (int i = 0; i < 12; i++) begin
      cfg_rand();
      a = 24'($urandom) & 24'hfffffe;
      op(1'b1, 1'b1, a, 16'($urandom));
      op(1'b0, 1'b1, a, 16'h0000);
      op(1'b1, 1'b0, a | 24'h1, 16'($urandom));
      op(1'b0, 1'b0, a | 24'h1, 16'h0000);
    end
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule
